// ### hdl/gpc_pkg.sv
// Operation
// - each pin is switched between input and output at any time by software
// - one write sets or clears only the pins whose mask bits are one
// - one write loads the whole output port at once
// - a pin raises an interrupt on level, rising, falling or both edges
// - eight pin interrupt channels, each on a chosen pin with own output
// - two group interrupts combine conditions of any pin set into one output
// - after reset each pin is input, default function, pull-up enabled
// - per-pin configuration selects gpio or a peripheral through a multiplexer
// - per-pin choice of pull-up, pull-down or repeater holding the last level
// - pseudo open-drain drives low only and releases instead of driving high
// - filtered pins reject about 10 ns glitches; filter is on after reset
// - per-pin hysteresis enable and input inverter toward internal logic
// - analog input mode disables the digital input and output path
package gpc_pkg;
    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [11:0] GPC_DIR = 12'h000;
    localparam logic [11:0] GPC_OUT = 12'h004;
    localparam logic [11:0] GPC_SET = 12'h008;
    localparam logic [11:0] GPC_CLR = 12'h00C;
    localparam logic [11:0] GPC_PIN = 12'h010;
    localparam logic [11:0] GPC_ISEL = 12'h020;
    localparam logic [11:0] GPC_IENR = 12'h024;
    localparam logic [11:0] GPC_IENF = 12'h028;
    localparam logic [11:0] GPC_IST = 12'h030;
    localparam logic [11:0] GPC_IMSK = 12'h034;
    localparam logic [11:0] GPC_GENA0 = 12'h040;
    localparam logic [11:0] GPC_GPOL0 = 12'h044;
    localparam logic [11:0] GPC_GENA1 = 12'h048;
    localparam logic [11:0] GPC_GPOL1 = 12'h04C;
    localparam logic [11:0] GPC_GCTL = 12'h050;
    localparam logic [11:0] GPC_PSEL = 12'h060;
    localparam logic [11:0] GPC_CFG = 12'h100;
    // -----------------------------------------------------------------
    // pin configuration fields
    // -----------------------------------------------------------------
    localparam int GPC_CFG_W = 11;
    localparam int GPC_F_FUNC = 0;
    localparam int GPC_F_MODE = 3;
    localparam int GPC_F_HYS = 5;
    localparam int GPC_F_INV = 6;
    localparam int GPC_F_DIG = 7;
    localparam int GPC_F_FOFF = 8;
    localparam int GPC_F_OD = 10;
    localparam logic [1:0] GPC_M_NONE = 2'h0;
    localparam logic [1:0] GPC_M_PD = 2'h1;
    localparam logic [1:0] GPC_M_PU = 2'h2;
    localparam logic [1:0] GPC_M_REP = 2'h3;
    localparam logic [10:0] GPC_CFG_RST = 11'h0B0;
    // -----------------------------------------------------------------
    // counts and timing
    // -----------------------------------------------------------------
    localparam int GPC_NCH = 8;
    localparam int GPC_NGRP = 2;
    localparam int GPC_CLK_NS = 50;
    localparam int GPC_GLITCH_NS = 10;
    localparam int GPC_GLITCH_CYC = (GPC_GLITCH_NS + GPC_CLK_NS - 1) / GPC_CLK_NS;
    localparam logic [31:0] GPC_FILT_PINS = 32'h0001_F800;
    localparam logic [31:0] GPC_RST_WORD = 32'h0000_0000;
endpackage : gpc_pkg

// ### hdl/gpc_port.sv
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module gpc_port #(
    parameter int NPINS = 32,
    parameter int NFUNC = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NPINS-1:0] pad_in,
    output logic [NPINS-1:0] pad_out,
    output logic [NPINS-1:0] pad_oe,
    output logic [NPINS-1:0] pad_pu,
    output logic [NPINS-1:0] pad_pd,
    output logic [NPINS-1:0] pad_hys,
    output logic [NPINS-1:0] pad_analog,
    input wire logic [NPINS*NFUNC-1:0] periph_out,
    input wire logic [NPINS*NFUNC-1:0] periph_oe,
    output logic [NPINS-1:0] periph_in,
    output logic [gpc_pkg::GPC_NCH-1:0] pint_irq,
    output logic [gpc_pkg::GPC_NGRP-1:0] grp_irq,
    output logic irq
);
    localparam int SW = $clog2(NPINS);
    localparam int FW = $clog2(NFUNC);
    localparam int CW = gpc_pkg::GPC_CFG_W;

    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] outv;
    logic [gpc_pkg::GPC_CFG_W-1:0] cfg [NPINS];
    logic [SW-1:0] psel [gpc_pkg::GPC_NCH];
    logic [gpc_pkg::GPC_NCH-1:0] isel, ienr, ienf, cprev;
    logic [9:0] ist, imsk;
    logic [NPINS-1:0] gena [gpc_pkg::GPC_NGRP];
    logic [NPINS-1:0] gpol [gpc_pkg::GPC_NGRP];
    logic [1:0] gand, gprev;
    logic [NPINS-1:0] samp, filt, seen, od_on;
    logic [gpc_pkg::GPC_NCH-1:0] cur, chan_edge;
    logic [31:0] next_rdata;
    logic req, wr;

    function automatic logic [31:0] gpc_mask(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : gpc_mask

    function automatic logic [31:0] gpc_pad(input logic [NPINS-1:0] v);
        return 32'(v);
    endfunction : gpc_pad

    // -----------------------------------------------------------------
    // bus slave
    // -----------------------------------------------------------------
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & wb_ack_o;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= gpc_pkg::GPC_RST_WORD;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= next_rdata;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            gpc_pkg::GPC_DIR: next_rdata = gpc_pad(dir);
            gpc_pkg::GPC_OUT: next_rdata = gpc_pad(outv);
            gpc_pkg::GPC_SET: next_rdata = gpc_pad(outv);
            gpc_pkg::GPC_PIN: next_rdata = gpc_pad(seen);
            gpc_pkg::GPC_ISEL: next_rdata = 32'(isel);
            gpc_pkg::GPC_IENR: next_rdata = 32'(ienr);
            gpc_pkg::GPC_IENF: next_rdata = 32'(ienf);
            gpc_pkg::GPC_IST: next_rdata = 32'(ist);
            gpc_pkg::GPC_IMSK: next_rdata = 32'(imsk);
            gpc_pkg::GPC_GENA0: next_rdata = gpc_pad(gena[0]);
            gpc_pkg::GPC_GPOL0: next_rdata = gpc_pad(gpol[0]);
            gpc_pkg::GPC_GENA1: next_rdata = gpc_pad(gena[1]);
            gpc_pkg::GPC_GPOL1: next_rdata = gpc_pad(gpol[1]);
            gpc_pkg::GPC_GCTL: next_rdata = 32'(gand);
            default: begin
                for (int c = 0; c < gpc_pkg::GPC_NCH; c++) begin
                    if (wb_adr_i == gpc_pkg::GPC_PSEL + 12'(4 * c)) begin
                        next_rdata = 32'(psel[c]);
                    end
                end
                for (int p = 0; p < NPINS; p++) begin
                    if (wb_adr_i == gpc_pkg::GPC_CFG + 12'(4 * p)) begin
                        next_rdata = 32'(cfg[p]);
                    end
                end
            end
        endcase
    end

    // -----------------------------------------------------------------
    // port direction and data
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir <= '0;
            outv <= '0;
        end else if (wr) begin
            if (wb_adr_i == gpc_pkg::GPC_DIR) begin
                dir <= NPINS'(gpc_mask(gpc_pad(dir), wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == gpc_pkg::GPC_OUT) begin
                outv <= NPINS'(gpc_mask(gpc_pad(outv), wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == gpc_pkg::GPC_SET) begin
                outv <= outv | NPINS'(gpc_mask(32'h0000_0000, wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == gpc_pkg::GPC_CLR) begin
                outv <= outv & ~NPINS'(gpc_mask(32'h0000_0000, wb_dat_i, wb_sel_i));
            end
        end
    end

    // -----------------------------------------------------------------
    // pin configuration
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NPINS; p++) begin
                cfg[p] <= gpc_pkg::GPC_CFG_RST;
            end
        end else if (wr) begin
            for (int p = 0; p < NPINS; p++) begin
                if (wb_adr_i == gpc_pkg::GPC_CFG + 12'(4 * p)) begin
                    cfg[p] <= CW'(gpc_mask(32'(cfg[p]), wb_dat_i, wb_sel_i));
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            samp <= '0;
            filt <= '0;
        end else begin
            samp <= pad_in;
            for (int p = 0; p < NPINS; p++) begin
                if (!gpc_pkg::GPC_FILT_PINS[p] || cfg[p][gpc_pkg::GPC_F_FOFF] ||
                    samp[p] == pad_in[p]) begin
                    filt[p] <= pad_in[p];
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < NPINS; p++) begin
            logic dig, od, drv, val;
            logic [FW-1:0] fn;
            logic [1:0] md;
            dig = cfg[p][gpc_pkg::GPC_F_DIG];
            od = cfg[p][gpc_pkg::GPC_F_OD];
            fn = cfg[p][gpc_pkg::GPC_F_FUNC +: FW];
            md = cfg[p][gpc_pkg::GPC_F_MODE +: 2];
            drv = (fn == '0) ? dir[p] : periph_oe[p*NFUNC + int'(fn)];
            val = (fn == '0) ? outv[p] : periph_out[p*NFUNC + int'(fn)];
            seen[p] = dig & (filt[p] ^ cfg[p][gpc_pkg::GPC_F_INV]);
            od_on[p] = od;
            pad_oe[p] = dig & drv & ~(od & val);
            pad_out[p] = val & ~od;
            pad_pu[p] = dig & ((md == gpc_pkg::GPC_M_PU) | ((md == gpc_pkg::GPC_M_REP) & filt[p]));
            pad_pd[p] = dig & ((md == gpc_pkg::GPC_M_PD) |
                               ((md == gpc_pkg::GPC_M_REP) & ~filt[p]));
            pad_hys[p] = cfg[p][gpc_pkg::GPC_F_HYS];
            pad_analog[p] = ~dig;
        end
    end

    assign periph_in = seen;

    // -----------------------------------------------------------------
    // pin and group interrupts
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            isel <= '0;
            ienr <= '0;
            ienf <= '0;
            imsk <= '0;
            gand <= '0;
            for (int c = 0; c < gpc_pkg::GPC_NCH; c++) begin
                psel[c] <= '0;
            end
            for (int g = 0; g < gpc_pkg::GPC_NGRP; g++) begin
                gena[g] <= '0;
                gpol[g] <= '0;
            end
        end else if (wr) begin
            case (wb_adr_i)
                gpc_pkg::GPC_ISEL: isel <= wb_dat_i[7:0];
                gpc_pkg::GPC_IENR: ienr <= wb_dat_i[7:0];
                gpc_pkg::GPC_IENF: ienf <= wb_dat_i[7:0];
                gpc_pkg::GPC_IMSK: imsk <= wb_dat_i[9:0];
                gpc_pkg::GPC_GCTL: gand <= wb_dat_i[1:0];
                gpc_pkg::GPC_GENA0: gena[0] <= NPINS'(wb_dat_i);
                gpc_pkg::GPC_GPOL0: gpol[0] <= NPINS'(wb_dat_i);
                gpc_pkg::GPC_GENA1: gena[1] <= NPINS'(wb_dat_i);
                gpc_pkg::GPC_GPOL1: gpol[1] <= NPINS'(wb_dat_i);
                default: begin
                    for (int c = 0; c < gpc_pkg::GPC_NCH; c++) begin
                        if (wb_adr_i == gpc_pkg::GPC_PSEL + 12'(4 * c)) begin
                            psel[c] <= wb_dat_i[SW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        for (int c = 0; c < gpc_pkg::GPC_NCH; c++) begin
            cur[c] = seen[psel[c]];
        end
    end

    assign chan_edge = (ienr & cur & ~cprev) | (ienf & ~cur & cprev);

    always_comb begin
        for (int g = 0; g < gpc_pkg::GPC_NGRP; g++) begin
            logic [NPINS-1:0] hit;
            hit = gena[g] & ~(seen ^ gpol[g]);
            grp_irq[g] = gand[g] ? ((|gena[g]) & (hit == gena[g])) : (|hit);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cprev <= '0;
            gprev <= '0;
            ist <= '0;
        end else begin
            cprev <= cur;
            gprev <= grp_irq;
            for (int c = 0; c < gpc_pkg::GPC_NCH; c++) begin
                if (isel[c]) begin
                    ist[c] <= ienr[c] & (cur[c] == ienf[c]);
                end else if (chan_edge[c]) begin
                    ist[c] <= 1'h1;
                end else if (wr && wb_adr_i == gpc_pkg::GPC_IST && wb_dat_i[c]) begin
                    ist[c] <= 1'h0;
                end
            end
            for (int g = 0; g < gpc_pkg::GPC_NGRP; g++) begin
                if (grp_irq[g] & ~gprev[g]) begin
                    ist[8 + g] <= 1'h1;
                end else if (wr && wb_adr_i == gpc_pkg::GPC_IST && wb_dat_i[8 + g]) begin
                    ist[8 + g] <= 1'h0;
                end
            end
        end
    end

    assign pint_irq = ist[7:0];
    assign irq = |(ist & imsk);

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_req;
        req & ~wb_ack_o;
    endsequence

    a_bus_ack_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_req ##1 wb_ack_o |=> !wb_ack_o)
        else $error("ack not single cycle");

    a_dir_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && wb_adr_i == gpc_pkg::GPC_DIR && wb_sel_i == 4'hF |=> dir == NPINS'($past(wb_dat_i)))
        else $error("direction write lost");

    a_set_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && wb_adr_i == gpc_pkg::GPC_SET |=>
            ((outv & ~$past(outv)) & ~NPINS'($past(wb_dat_i))) == '0 &&
            ($past(outv) & ~outv) == '0)
        else $error("set disturbed pins");

    a_port_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && wb_adr_i == gpc_pkg::GPC_OUT && wb_sel_i == 4'hF |=> outv == NPINS'($past(wb_dat_i)))
        else $error("port write lost");

    a_rise_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !isel[0] && ienr[0] && cur[0] && !cprev[0] |=> ist[0])
        else $error("rising edge missed");

    a_chan_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pint_irq == ist[7:0] && (irq == |(ist & imsk)))
        else $error("channel output wrong");

    a_group_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !gand[0] && (gena[0] & ~(seen ^ gpol[0])) != '0 |-> grp_irq[0])
        else $error("group or-mode missed");

    a_od_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (od_on & pad_oe & pad_out) == '0)
        else $error("open drain drove high");

    a_analog_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pad_analog & (pad_oe | seen | pad_pu | pad_pd)) == '0)
        else $error("analog pin active");

    a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ist[0] && !isel[0] && !(wr && wb_adr_i == gpc_pkg::GPC_IST) ##1 !isel[0] |-> ist[0])
        else $error("edge flag dropped");

endmodule : gpc_port

// ### test/gpc_board.sv
`timescale 1ns/1ps
// ------------------------------------------
// board signals seen at the pins
// ------------------------------------------
module gpc_board (
    input wire logic sys_clk,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    input wire logic [31:0] pad_pu,
    input wire logic [31:0] pad_pd,
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] pad_in
);
    logic flip = 1'h0;
    // floating pin without pull shows a changing level
    always @(posedge sys_clk) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pu[i]) begin
                pad_in[i] = 1'h1;
            end else if (pad_pd[i]) begin
                pad_in[i] = 1'h0;
            end else begin
                pad_in[i] = flip;
            end
        end
    end
endmodule : gpc_board

// ### test/gpio_port_with_pin_config_bench.sv
`timescale 1ns/1ps
module gpio_port_with_pin_config_bench;
    logic sys_clk = 1'h0, rst_n = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, irq;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rq;
    logic [31:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_hys, pad_analog, periph_in;
    logic [127:0] periph_out = '0, periph_oe = '0;
    logic [7:0] pint_irq;
    logic [1:0] grp_irq;
    logic [31:0] ext_en = 32'hFFEF_FFFF, ext_val = 32'h0000_0000;
    int n_fail = 0, num_checks = 0;

    gpc_port #(.NPINS(32), .NFUNC(4)) uut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pad_in,
        .pad_out, .pad_oe, .pad_pu, .pad_pd, .pad_hys, .pad_analog, .periph_out,
        .periph_oe, .periph_in, .pint_irq, .grp_irq, .irq);
    gpc_board board (.sys_clk, .pad_out, .pad_oe, .pad_pu, .pad_pd, .ext_en, .ext_val,
        .pad_in);

    always #25 sys_clk = ~sys_clk;

    // ------------------------------------------
    // bus and compare tasks
    // ------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'h1) begin
                break;
            end
        end
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        if (i < 20) begin
            rq = wb_dat_o;
            @(negedge sys_clk);
        end else begin
            n_fail++;
            results();
        end
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0000_0000);
        chk(rq, exp);
    endtask : rdc

    task automatic cfg(input int p, input logic [31:0] v);
        wr(gpc_pkg::GPC_CFG + 12'(p * 4), v);
    endtask : cfg

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    task automatic pin(input int p, input logic v);
        @(posedge sys_clk);
        ext_val[p] <= v;
    endtask : pin

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic t_reset;
        chk(pad_pu, 32'hFFFF_FFFF);
        chk(pad_oe | pad_pd | pad_analog, 32'h0000_0000);
        chk({irq, grp_irq, pint_irq}, 32'h0000_0000);
        rdc(gpc_pkg::GPC_CFG + 12'h02C, 32'h0000_00B0);
        rdc(gpc_pkg::GPC_PIN, 32'h0010_0000);
    endtask : t_reset

    task automatic t_out;
        wr(gpc_pkg::GPC_DIR, 32'hFFFF_0000);
        wr(gpc_pkg::GPC_OUT, 32'hA5A5_5A5A);
        chk(pad_oe, 32'hFFFF_0000);
        chk(pad_out & pad_oe, 32'hA5A5_0000);
        wr(gpc_pkg::GPC_SET, 32'h0F0F_0000);
        wr(gpc_pkg::GPC_CLR, 32'h00A0_0000);
        rdc(gpc_pkg::GPC_OUT, 32'hAF0F_5A5A);
        chk(pad_out & pad_oe, 32'hAF0F_0000);
        cyc(3);
        rdc(gpc_pkg::GPC_PIN, 32'hAF0F_0000);
        wr(gpc_pkg::GPC_DIR, 32'h0000_0000);
        chk(pad_oe, 32'h0000_0000);
        wr(12'h0F0, 32'hFFFF_FFFF);
        rdc(12'h0F0, 32'h0000_0000);
    endtask : t_out

    task automatic t_pint;
        for (int c = 0; c < 5; c++) begin
            wr(gpc_pkg::GPC_PSEL + 12'(c * 4), 32'h0000_0003);
        end
        wr(gpc_pkg::GPC_ISEL, 32'h0000_0018);
        wr(gpc_pkg::GPC_IENR, 32'h0000_001D);
        wr(gpc_pkg::GPC_IENF, 32'h0000_000E);
        wr(gpc_pkg::GPC_IMSK, 32'h0000_0001);
        wr(gpc_pkg::GPC_IST, 32'h0000_00FF);
        rdc(gpc_pkg::GPC_IST, 32'h0000_0010);
        pin(3, 1'h1);
        cyc(4);
        chk({irq, pint_irq}, 32'h0000_010D);
        pin(3, 1'h0);
        cyc(4);
        chk(pint_irq, 32'h0000_0017);
        wr(gpc_pkg::GPC_IST, 32'h0000_0007);
        rdc(gpc_pkg::GPC_IST, 32'h0000_0010);
        chk(irq, 32'h0000_0000);
        pin(3, 1'h1);
        cyc(4);
        wr(gpc_pkg::GPC_IMSK, 32'h0000_0000);
        chk({irq, pint_irq[0]}, 32'h0000_0001);
        wr(gpc_pkg::GPC_IENR, 32'h0000_0000);
        wr(gpc_pkg::GPC_IENF, 32'h0000_0000);
        wr(gpc_pkg::GPC_IST, 32'h0000_00FF);
    endtask : t_pint

    task automatic t_grp;
        wr(gpc_pkg::GPC_GPOL0, 32'h0000_0040);
        wr(gpc_pkg::GPC_GPOL1, 32'h0000_0040);
        wr(gpc_pkg::GPC_GCTL, 32'h0000_0002);
        wr(gpc_pkg::GPC_GENA0, 32'h0000_0040);
        wr(gpc_pkg::GPC_GENA1, 32'h0000_00C0);
        wr(gpc_pkg::GPC_IST, 32'h0000_0300);
        chk(grp_irq, 32'h0000_0000);
        pin(6, 1'h1);
        cyc(4);
        chk(grp_irq, 32'h0000_0003);
        rdc(gpc_pkg::GPC_IST, 32'h0000_0300);
        pin(7, 1'h1);
        cyc(4);
        chk(grp_irq, 32'h0000_0001);
        wr(gpc_pkg::GPC_GENA0, 32'h0000_0000);
        wr(gpc_pkg::GPC_GENA1, 32'h0000_0000);
    endtask : t_grp

    task automatic t_cfg;
        cfg(8, 32'h0000_00A8);
        chk({pad_pu[8], pad_pd[8], pad_hys[8]}, 32'h0000_0003);
        cfg(8, 32'h0000_0098);
        pin(8, 1'h1);
        cyc(4);
        chk({pad_pu[8], pad_pd[8]}, 32'h0000_0002);
        pin(8, 1'h0);
        cyc(4);
        chk({pad_pu[8], pad_pd[8]}, 32'h0000_0001);
        cfg(8, 32'h0000_00C0);
        pin(8, 1'h1);
        cyc(4);
        chk(periph_in[8], 32'h0000_0000);
        cfg(8, 32'h0000_0000);
        wr(gpc_pkg::GPC_DIR, 32'h0000_0100);
        wr(gpc_pkg::GPC_OUT, 32'h0000_0100);
        chk({pad_analog[8], periph_in[8], pad_oe[8]}, 32'h0000_0004);
        cfg(8, 32'h0000_0480);
        chk(pad_oe[8], 32'h0000_0000);
        wr(gpc_pkg::GPC_OUT, 32'h0000_0000);
        chk({pad_oe[8], pad_out[8]}, 32'h0000_0002);
        cfg(8, 32'h0000_0081);
        chk({pad_oe[8], pad_out[8]}, 32'h0000_0000);
        @(posedge sys_clk);
        periph_out[33] <= 1'h1;
        periph_oe[33] <= 1'h1;
        cyc(1);
        chk({pad_oe[8], pad_out[8]}, 32'h0000_0003);
        cfg(8, 32'h0000_00B0);
        wr(gpc_pkg::GPC_DIR, 32'h0000_0000);
    endtask : t_cfg

    task automatic t_filt;
        logic seen;
        pin(11, 1'h1);
        pin(11, 1'h0);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk(periph_in[11], 32'h0000_0000);
        end
        pin(11, 1'h1);
        cyc(4);
        chk(periph_in[11], 32'h0000_0001);
        pin(11, 1'h0);
        cfg(11, 32'h0000_01B0);
        seen = 1'h0;
        pin(11, 1'h1);
        pin(11, 1'h0);
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            seen = seen | periph_in[11];
        end
        chk(seen, 32'h0000_0001);
    endtask : t_filt

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'h1;
        cyc(3);
        t_reset();
        t_out();
        t_pint();
        t_grp();
        t_cfg();
        t_filt();
        results();
    end
endmodule : gpio_port_with_pin_config_bench
